// ==== verilog/lsfs_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module lsfs_top #(
  parameter int unsigned PRESCALE  = lsfs_pkg::TICK_CYC,
  parameter int unsigned OFF_TICKS = lsfs_pkg::OFF_TICKS_DEF
) (
  input  wire logic                  MCLK,
  input  wire logic                  SYS_RST,
  input  wire lsfs_pkg::lsfs_flags_t FLAGS,
  input  wire logic [11:0]           IOUT_MA,
  input  wire logic [15:0]           VBASE_MV,
  input  wire logic [7:0]            ADDR,
  input  wire logic [31:0]           WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic [31:0]                RDATA,
  output logic                       SWITCH_EN,
  output logic                       RP_EN,
  output logic                       HANDSHAKE_RESTART,
  output logic [15:0]                VOUT_TARGET_MV,
  output logic                       IRQ
);
  import lsfs_pkg::*;

  localparam int PW = $clog2(PRESCALE + 1);
  localparam int TW = $clog2(OFF_TICKS + 1);

  if (PRESCALE < 2 || OFF_TICKS < 1) begin : g_chk
    $error("lsfs_top: PRESCALE must be >= 2 and OFF_TICKS >= 1");
  end

  // ==========================================================
  // Flag synchronisers
  lsfs_flags_t meta_r;
  lsfs_flags_t f;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      meta_r <= '0;
      f      <= '0;
    end else begin
      meta_r <= FLAGS;
      f      <= meta_r;
    end
  end

  // ==========================================================
  // Millisecond timebase and off timer
  logic [PW-1:0] presc_r;
  logic [TW-1:0] tmr_r;
  logic          tmr_clr;
  wire           ms_tick  = (presc_r == PW'(PRESCALE - 1));
  wire           tmr_done = (tmr_r == TW'(OFF_TICKS));

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      presc_r <= '0;
      tmr_r   <= '0;
    end else if (tmr_clr) begin
      presc_r <= '0;
      tmr_r   <= '0;
    end else begin
      presc_r <= ms_tick ? '0 : presc_r + 1'b1;
      if (ms_tick && !tmr_done)
        tmr_r <= tmr_r + 1'b1;
    end
  end

  // ==========================================================
  // Supervisor state machine
  lsfs_state_t       st_r, st_nxt;
  logic [NCAUSE-1:0] cause_r, cause_nxt;
  logic              pend_r, pend_nxt;
  logic              restart_nxt;
  logic [15:0]       retry_r;
  lsfs_ctrl_t        ctrl_r;

  wire [NCAUSE-1:0] trip = {f.data_above_hi, f.cc_above_hi, f.temp_hot,
                            f.supply_above_hi, f.over_current_fault};
  wire [NCAUSE-1:0] late = {f.data_above_hi, f.cc_above_hi, f.temp_hot, 2'b00};
  wire hold_ot  = cause_r[C_OT] && !f.temp_cool;
  wire hold_cc  = cause_r[C_CC] && !f.cc_below_lo;
  wire hold_dat = cause_r[C_DAT] && !f.data_below_lo;
  wire hold_sup = cause_r[C_SUP] && f.supply_above_hi;
  wire all_clear = !(hold_ot || hold_cc || hold_dat || hold_sup);
  wire oc_only   = (cause_r == NCAUSE'(1 << C_OC));

  always_comb begin
    st_nxt      = st_r;
    cause_nxt   = cause_r;
    pend_nxt    = pend_r;
    restart_nxt = 1'b0;
    tmr_clr     = 1'b0;
    case (st_r)
      ST_IDLE: begin
        // Only the low supply threshold applies before switch-on
        if (ctrl_r.enable && f.attached && !f.supply_above_lo)
          st_nxt = ST_ON;
      end
      ST_ON: begin
        if (|trip) begin
          st_nxt    = ST_FAULT;
          cause_nxt = trip;
          pend_nxt  = 1'b0;
          tmr_clr   = 1'b1;
        end else if (!f.attached || !ctrl_r.enable) begin
          st_nxt   = ST_IDLE;
          pend_nxt = 1'b0;
        end else if (pend_r && ms_tick) begin
          pend_nxt    = 1'b0;
          restart_nxt = 1'b1;
        end
      end
      ST_FAULT: begin
        cause_nxt = cause_r | late;
        if (tmr_done) begin
          if (!all_clear) begin
            tmr_clr = 1'b1;
          end else if (oc_only) begin
            st_nxt   = ST_ON;
            pend_nxt = 1'b1;
          end else begin
            st_nxt      = ST_IDLE;
            restart_nxt = 1'b1;
          end
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_r              <= ST_IDLE;
      cause_r           <= '0;
      pend_r            <= 1'b0;
      HANDSHAKE_RESTART <= 1'b0;
    end else begin
      st_r              <= st_nxt;
      cause_r           <= cause_nxt;
      pend_r            <= pend_nxt;
      HANDSHAKE_RESTART <= restart_nxt;
    end
  end

  assign SWITCH_EN = (st_r == ST_ON);
  // Pull-ups are forced on while protection holds the switch off
  assign RP_EN = ctrl_r.rp_en || (st_r == ST_FAULT);

  // ==========================================================
  // Cable drop compensation
  wire [19:0] comp_prod = IOUT_MA * 8'(COMP_MV_PER_A);
  wire [15:0] comp_mv   = 16'(comp_prod / 20'(MA_PER_A));

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST)
      VOUT_TARGET_MV <= '0;
    else
      VOUT_TARGET_MV <= VBASE_MV + (ctrl_r.comp_en ? comp_mv : 16'h0000);
  end

  // ==========================================================
  // Register file and interrupts
  logic [NEV-1:0] irq_st_r, irq_en_r;
  wire  wr_ctrl = WR && (ADDR == ADR_CTRL);
  wire  wr_clr  = WR && (ADDR == ADR_IRQ_CL);
  wire  wr_en   = WR && (ADDR == ADR_IRQ_EN);
  wire  wr_rtry = WR && (ADDR == ADR_RETRY);
  wire  [NEV-1:0] ev = {restart_nxt, (st_r == ST_ON) ? trip : 5'h00};
  wire  [NEV-1:0] clr_mask = wr_clr ? WDATA[NEV-1:0] : '0;
  wire  retry_ev = (st_r == ST_FAULT) && tmr_done;
  wire  [31:0] status_w = {23'h0, cause_r, pend_r, SWITCH_EN, st_r};
  wire  [31:0] rd_mux =
      (ADDR == ADR_CTRL)   ? {29'h0, ctrl_r} :
      (ADDR == ADR_STATUS) ? status_w :
      (ADDR == ADR_IRQ_ST) ? {26'h0, irq_st_r} :
      (ADDR == ADR_IRQ_EN) ? {26'h0, irq_en_r} :
      (ADDR == ADR_RETRY)  ? {16'h0, retry_r} : 32'h0000_0000;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_r   <= CTRL_RST;
      irq_st_r <= '0;
      irq_en_r <= '0;
      retry_r  <= '0;
      RDATA    <= '0;
    end else begin
      if (wr_ctrl)
        ctrl_r <= lsfs_ctrl_t'(WDATA[2:0]);
      if (wr_en)
        irq_en_r <= WDATA[NEV-1:0];
      // Set wins over a clear arriving in the same cycle
      irq_st_r <= (irq_st_r & ~clr_mask) | ev;
      if (retry_ev)
        retry_r <= retry_r + 1'b1;
      else if (wr_rtry)
        retry_r <= '0;
      RDATA <= RD ? rd_mux : '0;
    end
  end

  assign IRQ = |(irq_st_r & irq_en_r);

  // ==========================================================
  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  sequence s_oc_trip;
    (st_r == ST_ON) && f.over_current_fault;
  endsequence
  sequence s_off_wait;
    (st_r == ST_FAULT) && !tmr_done;
  endsequence

  property p_oc_off;
    s_oc_trip |=> (st_r == ST_FAULT) && !SWITCH_EN && (tmr_r == '0);
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("over-current did not open switch");

  property p_hold_off;
    s_off_wait |=> !SWITCH_EN && (st_r == ST_FAULT);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("switch left off state early");

  property p_hiccup;
    (st_r == ST_FAULT) && tmr_done && oc_only |=> SWITCH_EN && pend_r;
  endproperty
  a_hiccup: assert property (p_hiccup) else $error("over-current retry missing");

  property p_restart;
    (st_r == ST_ON) && pend_r && ms_tick && !(|trip) && f.attached && ctrl_r.enable
      |=> HANDSHAKE_RESTART ##1 !HANDSHAKE_RESTART;
  endproperty
  a_restart: assert property (p_restart) else $error("handshake restart not pulsed");

  property p_low_ov;
    (st_r == ST_IDLE) && f.supply_above_lo |=> !SWITCH_EN;
  endproperty
  a_low_ov: assert property (p_low_ov) else $error("switch on above low threshold");

  property p_high_ov;
    (st_r == ST_ON) && f.supply_above_hi |=> !SWITCH_EN [*2];
  endproperty
  a_high_ov: assert property (p_high_ov) else $error("high supply did not trip");

  property p_hot;
    (st_r == ST_FAULT) && cause_r[C_OT] && !f.temp_cool |=> (st_r == ST_FAULT);
  endproperty
  a_hot: assert property (p_hot) else $error("left off before cooling");

  property p_cc_hyst;
    (st_r == ST_FAULT) && cause_r[C_CC] && !f.cc_below_lo |=> !SWITCH_EN;
  endproperty
  a_cc_hyst: assert property (p_cc_hyst) else $error("cc hysteresis violated");

  property p_dat_hyst;
    (st_r == ST_FAULT) && cause_r[C_DAT] && !f.data_below_lo |=> !SWITCH_EN;
  endproperty
  a_dat_hyst: assert property (p_dat_hyst) else $error("data hysteresis violated");

  property p_rp;
    (st_r == ST_FAULT) |-> RP_EN && !SWITCH_EN;
  endproperty
  a_rp: assert property (p_rp) else $error("pull-ups dropped in fault");

  property p_comp;
    ctrl_r.comp_en |=> VOUT_TARGET_MV == $past(VBASE_MV) + 16'($past(IOUT_MA) / 8);
  endproperty
  a_comp: assert property (p_comp) else $error("compensation offset wrong");

  property p_sync;
    $rose(FLAGS.over_current_fault) ##1 FLAGS.over_current_fault
      |=> $rose(f.over_current_fault);
  endproperty
  a_sync: assert property (p_sync) else $error("flag synchroniser latency wrong");

  // Length of the current off spell; saturates so a stuck fault cannot wrap it
  logic [31:0] off_len_r;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST)
      off_len_r <= '0;
    else if (st_r != ST_FAULT)
      off_len_r <= '0;
    else if (!(&off_len_r))
      off_len_r <= off_len_r + 1'b1;
  end

  property p_off_min;
    (st_r == ST_FAULT) && (st_nxt != ST_FAULT) |-> off_len_r >= 32'(PRESCALE * OFF_TICKS);
  endproperty
  a_off_min: assert property (p_off_min) else $error("off spell too short");

  property p_irq_set;
    (st_r == ST_ON) && f.over_current_fault |=> irq_st_r[C_OC];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("over-current event not latched");
endmodule
`default_nettype wire

// ==== verilog/lsfs_pkg.sv ====
`default_nettype none
package lsfs_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_NS       = 1000000;
  localparam int unsigned TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned OFF_TIME_MS   = 1000;
  localparam int unsigned OFF_TICKS_DEF = OFF_TIME_MS * 1000000 / TICK_NS;
  localparam int unsigned COMP_MV_PER_A = 125;
  localparam int unsigned MA_PER_A      = 1000;
  // ==========================================================
  // Register map
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_IRQ_ST = 8'h08;
  localparam logic [7:0] ADR_IRQ_CL = 8'h0c;
  localparam logic [7:0] ADR_IRQ_EN = 8'h10;
  localparam logic [7:0] ADR_RETRY  = 8'h14;
  localparam logic [2:0] CTRL_RST   = 3'h7;
  localparam int unsigned NCAUSE = 5;
  localparam int unsigned NEV    = 6;
  localparam int unsigned C_OC   = 0;
  localparam int unsigned C_SUP  = 1;
  localparam int unsigned C_OT   = 2;
  localparam int unsigned C_CC   = 3;
  localparam int unsigned C_DAT  = 4;
  localparam int unsigned EV_RST = 5;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_FAULT} lsfs_state_t;
  typedef struct packed {
    logic comp_en;
    logic rp_en;
    logic enable;
  } lsfs_ctrl_t;
  typedef struct packed {
    logic attached;
    logic data_below_lo;
    logic data_above_hi;
    logic cc_below_lo;
    logic cc_above_hi;
    logic temp_cool;
    logic temp_hot;
    logic supply_above_hi;
    logic supply_above_lo;
    logic over_current_fault;
  } lsfs_flags_t;
endpackage
`default_nettype wire

// ==== test/lsfs_sink_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lsfs_sink_model (
  input  wire logic                  mclk,
  input  wire logic                  att,
  input  wire logic                  oc,
  input  wire logic [15:0]           vin_mv,
  input  wire logic [15:0]           cc_mv,
  input  wire logic [15:0]           dat_mv,
  input  wire logic [7:0]            temp_c,
  input  wire logic                  restart,
  output var  lsfs_pkg::lsfs_flags_t flags,
  output var  int                    n_restart
);
  import lsfs_pkg::*;
  // ====================================
  // Comparators, with gaps between trip and release for data, CC and temperature
  assign flags = {att,
                  dat_mv < 16'h0fa0, dat_mv > 16'h1194,
                  cc_mv < 16'h157c, cc_mv > 16'h1770,
                  temp_c < 8'h46, temp_c > 8'h91,
                  vin_mv > 16'h36b0,
                  vin_mv > 16'h15e0,
                  oc};
  // ====================================
  // Sink side: counts each restart pulse
  int cnt = 0;
  assign n_restart = cnt;
  always @(posedge mclk) begin
    if (restart === 1'b1) cnt <= cnt + 1;
  end
endmodule
`default_nettype wire

// ==== test/lsfs_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module lsfs_top_tb_top;
  import lsfs_pkg::*;
  localparam int unsigned PS   = 4;
  localparam int unsigned OT   = 3;
  localparam int unsigned TOFF = PS * OT;
  localparam logic [15:0] HI  [4] = '{16'h3a98, 16'h0096, 16'h1964, 16'h1388};
  localparam logic [15:0] MID [4] = '{16'h2710, 16'h0064, 16'h16a8, 16'h1068};
  localparam logic [15:0] LO  [4] = '{16'h1388, 16'h0019, 16'h0000, 16'h0000};
  logic        mclk = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
  logic        att = 1'b0, oc = 1'b0, sw, rp, hs, irq;
  logic [7:0]  temp = 8'h19, addr = 8'h00, seed = 8'h1b;
  logic [11:0] iout = 12'h000;
  logic [15:0] vbase = 16'h1388, supply_input = 16'h1388, cc = 16'h0000, dat = 16'h0000, vout;
  logic [31:0] wdata = 32'h0, rdata;
  lsfs_flags_t flags;
  int          n_rst, n0, t, n_fail = 0, cmp_count = 0;
  logic [31:0] q [$];

  always #12.5 mclk = ~mclk;

  lsfs_sink_model sink_u (.mclk(mclk), .att(att), .oc(oc), .vin_mv(supply_input), .cc_mv(cc),
    .dat_mv(dat), .temp_c(temp), .restart(hs), .flags(flags), .n_restart(n_rst));
  lsfs_top #(.PRESCALE(PS), .OFF_TICKS(OT)) dut_u (.MCLK(mclk), .SYS_RST(sys_rst),
    .FLAGS(flags), .IOUT_MA(iout), .VBASE_MV(vbase), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .SWITCH_EN(sw), .RP_EN(rp), .HANDSHAKE_RESTART(hs),
    .VOUT_TARGET_MV(vout), .IRQ(irq));

  // ====================================
  // Checking
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp);
  endtask

  task automatic chk_vout(input logic [31:0] got, input logic [31:0] exp);
    chk(got, exp);
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    if (rd_q) chk_rd(rdata, q.pop_front());
    rd_q <= rd;
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // ====================================
  // Drivers
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    q.push_back(e);
    @(posedge mclk);
    rd <= 1'b0;
  endtask

  task automatic set_lvl(input int i, input logic [15:0] v);
    @(posedge mclk);
    case (i)
      0: supply_input <= v;
      1: temp <= v[7:0];
      2: cc <= v;
      default: dat <= v;
    endcase
  endtask

  task automatic wait_sw(input logic v, input int lim);
    t = 0;
    while (sw !== v && t < lim) begin
      @(posedge mclk);
      #1;
      t++;
    end
    chk(sw, v);
  endtask

  // Switch off while the pull-ups stay applied
  task automatic hold_off(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
      chk({sw, rp}, 2'b01);
    end
  endtask

  // ====================================
  // Scenarios
  initial begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk({sw, rp, hs, irq}, 4'b0100);
    rd_reg(ADR_CTRL, 32'h7);
    rd_reg(8'h3c, 32'h0);
    wr_reg(ADR_IRQ_EN, 32'h3f);
    rd_reg(ADR_IRQ_EN, 32'h3f);
    set_lvl(0, 16'h1770);
    att <= 1'b1;
    hold_off(20);
    set_lvl(0, 16'h1388);
    wait_sw(1'b1, 10);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      @(posedge mclk);
      iout <= {seed, seed[3:0]};
      vbase <= {8'h13, seed};
      repeat (3) @(posedge mclk);
      #1;
      chk_vout(vout, 32'({8'h13, seed}) + 32'({seed, seed[3:0]}) * 32'h7d / 32'h3e8);
    end
    n0 = n_rst;
    // Pull-ups off by register, so only the fault state can apply them
    wr_reg(ADR_CTRL, 32'h5);
    #1;
    chk(rp, 1'b0);
    @(posedge mclk);
    oc <= 1'b1;
    repeat (2) begin
      wait_sw(1'b0, 8);
      hold_off(TOFF - 2);
      wait_sw(1'b1, 8);
    end
    wait_sw(1'b0, 8);
    chk(irq, 1'b1);
    rd_reg(ADR_IRQ_ST, 32'h1);
    @(posedge mclk);
    oc <= 1'b0;
    wr_reg(ADR_IRQ_CL, 32'h3f);
    rd_reg(ADR_IRQ_ST, 32'h0);
    #1;
    chk(irq, 1'b0);
    wait_sw(1'b1, 20);
    repeat (12) @(posedge mclk);
    chk(n_rst - n0, 1);
    rd_reg(ADR_IRQ_ST, 32'h20);
    rd_reg(ADR_STATUS, 32'h15);
    wr_reg(ADR_CTRL, 32'h7);
    wr_reg(ADR_RETRY, 32'h0);
    rd_reg(ADR_RETRY, 32'h0);
    for (int i = 0; i < 4; i++) begin
      n0 = n_rst;
      set_lvl(i, HI[i]);
      wait_sw(1'b0, 8);
      set_lvl(i, MID[i]);
      hold_off(3 * TOFF);
      set_lvl(i, LO[i]);
      wait_sw(1'b1, 2 * TOFF + 10);
      chk(n_rst - n0, 1);
    end
    repeat (4) @(posedge mclk);
    report_and_stop();
  end

  // Whole run needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
